// file: hw/isar_pkg.sv
// Purpose: shared constants and types of the two-wire slave receiver
// Assumes: one system clock; bus pins sampled, never used as a clock
// Notes: mode bit 0 selects 10-bit addressing, bit 1 start/stop events
`default_nettype none
package isar_pkg;
  localparam logic [1:0] MODE_7B = 2'h0;
  localparam logic [1:0] MODE_10B = 2'h1;
  localparam logic [1:0] MODE_7B_SP = 2'h2;
  localparam logic [1:0] MODE_10B_SP = 2'h3;
  localparam int MODE_TEN_POS = 0;
  localparam int MODE_SP_POS = 1;
  localparam logic [4:0] HI10_PAT = 5'h1e;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic CKP_RST = 1'h1;
  localparam int FIFO_DEPTH = 16;
  localparam int RX_W = 9;

  typedef struct packed {
    logic [1:0] mode;
    logic stretch_en;
    logic addr_hold_en;
    logic data_hold_en;
    logic buffer_overwrite_enable;
  } isar_cfg_t;

  typedef struct packed {
    logic event_flag;
    logic update_addr;
    logic buf_full;
    logic rx_ovf;
    logic clk_release;
    logic ack_time;
    logic start_seen;
    logic stop_seen;
    logic rw;
    logic data_n_addr;
  } isar_stat_t;

  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } isar_rx_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ADDR_LO = 5'h04,
    ST_DATA = 5'h08,
    ST_READ = 5'h10
  } isar_state_t;
endpackage : isar_pkg
`default_nettype wire

// file: hw/isar_top.sv
// Purpose: slave address match and receive path of a two-wire port
// Assumes: scl and sda come from pins, 2-flop synchronised here
// Notes: transmit side is not built; a matched read just parks the fsm
`default_nettype none
////////////////////////////////////////////////////////////////////////
module isar_fifo #(
  parameter int W = isar_pkg::RX_W,
  parameter int DEPTH = isar_pkg::FIFO_DEPTH
) (
  input wire logic i_clk, // system clock
  input wire logic i_resetn, // async reset, low
  input wire logic i_valid, // write request
  output logic o_ready, // not full
  input wire logic [W-1:0] i_data, // write word
  output logic o_valid, // not empty
  input wire logic i_ready, // reader pops
  output logic [W-1:0] o_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;
  logic full;
  assign full = (wp_ff[AW] != rp_ff[AW]) &&
                (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign o_ready = !full;
  assign o_valid = (wp_ff != rp_ff);
  assign o_data = mem[rp_ff[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (i_valid && !full) begin
      mem[wp_ff[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (i_valid && !full) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (i_ready && o_valid) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule : isar_fifo

////////////////////////////////////////////////////////////////////////
module isar_top (
  input wire logic i_clk, // system clock 125 MHz
  input wire logic i_resetn, // async reset, low
  input wire logic i_scl, // scl pin level
  input wire logic i_sda, // sda pin level
  output logic o_scl_o, // scl drive value
  output logic o_scl_oe_n, // scl drive enable, low drives
  output logic o_sda_o, // sda drive value
  output logic o_sda_oe_n, // sda drive enable, low drives
  input wire isar_pkg::isar_cfg_t i_cfg, // static configuration
  input wire logic [7:0] i_own_addr, // own_address_reg value
  input wire logic i_own_addr_wr, // own_address_reg write pulse
  input wire logic i_ack_value, // ack_value_bit, 0 acks
  input wire logic i_clk_release_set, // sets clock_release_bit
  input wire logic i_event_clr, // clears serial_event_flag
  input wire logic i_ovf_clr, // clears receive_overflow_flag
  input wire logic i_rx_rd, // pops receive_buffer
  output isar_pkg::isar_rx_t o_rx, // receive_buffer head
  output logic o_rx_valid, // receive_buffer not empty
  output isar_pkg::isar_stat_t o_stat // status bits
);
  // package items are named in full; nothing is imported
  logic scl_m_ff, scl_s_ff, scl_p_ff;
  logic sda_m_ff, sda_s_ff, sda_p_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic skip_ff;
  isar_pkg::isar_state_t st_ff, tgt_ff;
  logic ua_pend_ff, prior_ff, ok_ff, hold_pend_ff, ack_drive_ff;
  logic ev_ff, ua_ff, ckp_ff, ovf_ff, ack_time_ff;
  logic start_seen_ff, stop_seen_ff, rw_ff, dna_ff;
  logic scl_rise, scl_fall, start_det, stop_det, active;
  logic bit8_fall, bit9_fall, ten, sp_mode, rw_bit;
  logic m7, mhi, addr_ok, lo_ok, is_addr, accept, overflow;
  logic ack_ok, hold, hold_any, fifo_ready, push, ua_set9;
  isar_pkg::isar_rx_t push_word;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_m_ff <= 1'h1;
      scl_s_ff <= 1'h1;
      scl_p_ff <= 1'h1;
      sda_m_ff <= 1'h1;
      sda_s_ff <= 1'h1;
      sda_p_ff <= 1'h1;
    end else begin
      scl_m_ff <= i_scl;
      scl_s_ff <= scl_m_ff;
      scl_p_ff <= scl_s_ff;
      sda_m_ff <= i_sda;
      sda_s_ff <= sda_m_ff;
      sda_p_ff <= sda_s_ff;
    end
  end

  assign scl_rise = scl_s_ff && !scl_p_ff;
  assign scl_fall = !scl_s_ff && scl_p_ff;
  // sda moving while scl stays high is a condition, not data
  assign start_det = !sda_s_ff && sda_p_ff && scl_s_ff && scl_p_ff;
  assign stop_det = sda_s_ff && !sda_p_ff && scl_s_ff && scl_p_ff;
  assign active = (st_ff == isar_pkg::ST_ADDR) ||
                  (st_ff == isar_pkg::ST_ADDR_LO) ||
                  (st_ff == isar_pkg::ST_DATA);
  assign bit8_fall = scl_fall && !skip_ff && active &&
                     (cnt_ff == isar_pkg::LAST_BIT);
  assign bit9_fall = scl_fall && !skip_ff && active &&
                     (cnt_ff == isar_pkg::ACK_SLOT);

  ////////////////////////////////////////////////////////////////////
  // bit engine: the scl fall that ends a start is not a data bit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= '0;
      shift_ff <= '0;
      skip_ff <= 1'h0;
    end else if (start_det) begin
      cnt_ff <= '0;
      skip_ff <= 1'h1;
    end else begin
      if (scl_rise && cnt_ff < isar_pkg::ACK_SLOT) begin
        shift_ff <= {shift_ff[6:0], sda_s_ff};
      end
      if (scl_fall && skip_ff) begin
        skip_ff <= 1'h0;
      end else if (bit9_fall) begin
        cnt_ff <= '0;
      end else if (scl_fall && active) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // byte decisions at the eighth fall
  assign ten = i_cfg.mode[isar_pkg::MODE_TEN_POS];
  assign sp_mode = i_cfg.mode[isar_pkg::MODE_SP_POS];
  assign rw_bit = shift_ff[0];
  assign m7 = (shift_ff[7:1] == i_own_addr[7:1]);
  assign mhi = (shift_ff[7:3] == isar_pkg::HI10_PAT) &&
               (shift_ff[2:1] == i_own_addr[2:1]);
  // a 10-bit read is taken only after a full write match
  assign addr_ok = ten ? (mhi && (!rw_bit || prior_ff)) : m7;
  assign lo_ok = (shift_ff == i_own_addr);
  assign is_addr = (st_ff != isar_pkg::ST_DATA);
  assign accept = (st_ff == isar_pkg::ST_ADDR && addr_ok) ||
                  (st_ff == isar_pkg::ST_ADDR_LO && lo_ok) ||
                  (st_ff == isar_pkg::ST_DATA);
  // overwrite enable ignores the sticky overflow, not a full buffer
  assign overflow = i_cfg.buffer_overwrite_enable ? !fifo_ready :
                    (!fifo_ready || ovf_ff);
  assign ack_ok = accept && !overflow;
  assign hold_any = i_cfg.addr_hold_en || i_cfg.data_hold_en;
  assign hold = is_addr ? i_cfg.addr_hold_en : i_cfg.data_hold_en;
  assign push = bit8_fall && ack_ok;
  assign push_word = '{is_data: !is_addr, value: shift_ff};
  assign ua_set9 = ua_pend_ff &&
                   (ack_drive_ff || st_ff == isar_pkg::ST_ADDR_LO);

  ////////////////////////////////////////////////////////////////////
  // transfer state machine
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= isar_pkg::ST_IDLE;
      tgt_ff <= isar_pkg::ST_IDLE;
      ua_pend_ff <= 1'h0;
      prior_ff <= 1'h0;
    end else if (start_det) begin
      st_ff <= isar_pkg::ST_ADDR; // restart acts as start
    end else if (stop_det) begin
      st_ff <= isar_pkg::ST_IDLE;
      prior_ff <= 1'h0;
    end else if (bit8_fall) begin
      case (st_ff)
        isar_pkg::ST_ADDR: begin
          if (!addr_ok) begin
            st_ff <= isar_pkg::ST_IDLE;
          end
          if (ten && (!mhi || !rw_bit)) begin
            prior_ff <= 1'h0;
          end
          ua_pend_ff <= ten && !rw_bit && addr_ok;
          tgt_ff <= rw_bit ? isar_pkg::ST_READ :
                    (ten ? isar_pkg::ST_ADDR_LO : isar_pkg::ST_DATA);
        end
        isar_pkg::ST_ADDR_LO: begin
          ua_pend_ff <= 1'h1;
          prior_ff <= ack_ok;
          tgt_ff <= lo_ok ? isar_pkg::ST_DATA : isar_pkg::ST_IDLE;
        end
        default: begin
          ua_pend_ff <= 1'h0;
          tgt_ff <= isar_pkg::ST_DATA;
        end
      endcase
    end else if (bit9_fall) begin
      if (ack_drive_ff || st_ff == isar_pkg::ST_ADDR_LO) begin
        st_ff <= tgt_ff;
      end else begin
        st_ff <= isar_pkg::ST_IDLE;
      end
      ua_pend_ff <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // acknowledge: hardware decides unless the hold mode for that byte kind (address or data) is on
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_drive_ff <= 1'h0;
      hold_pend_ff <= 1'h0;
      ok_ff <= 1'h0;
      ack_time_ff <= 1'h0;
    end else if (start_det || stop_det || bit9_fall) begin
      ack_drive_ff <= 1'h0;
      hold_pend_ff <= 1'h0;
      ack_time_ff <= 1'h0;
    end else if (bit8_fall) begin
      ok_ff <= ack_ok;
      hold_pend_ff <= accept && hold;
      ack_drive_ff <= hold ? (ack_ok && !i_ack_value)
                           : ack_ok;
      ack_time_ff <= accept && hold_any;
    end else if (hold_pend_ff) begin
      // track the bit until the ninth fall closes the ack slot
      ack_drive_ff <= ok_ff && !i_ack_value;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software-visible flags; hardware update beats software write
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_ff <= 1'h0;
      ua_ff <= 1'h0;
      ckp_ff <= isar_pkg::CKP_RST;
      ovf_ff <= 1'h0;
    end else begin
      ev_ff <= ((start_det || stop_det) && sp_mode) ||
               (bit8_fall && accept && hold) ||
               (bit9_fall && (ack_drive_ff || ua_set9)) ||
               (ev_ff && !i_event_clr);
      ua_ff <= (bit9_fall && ua_set9) ||
               (ua_ff && !i_own_addr_wr);
      if (bit8_fall && accept && hold) begin
        ckp_ff <= 1'h0;
      end else if (bit9_fall && ack_drive_ff && i_cfg.stretch_en &&
                   !ua_pend_ff && tgt_ff != isar_pkg::ST_READ) begin
        ckp_ff <= 1'h0;
      end else if (i_clk_release_set) begin
        ckp_ff <= 1'h1;
      end
      ovf_ff <= (bit8_fall && st_ff == isar_pkg::ST_DATA && overflow) ||
                (ovf_ff && !i_ovf_clr);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      start_seen_ff <= 1'h0;
      stop_seen_ff <= 1'h0;
      rw_ff <= 1'h0;
      dna_ff <= 1'h0;
    end else begin
      if (start_det) begin
        start_seen_ff <= 1'h1;
        stop_seen_ff <= 1'h0;
      end else if (stop_det) begin
        start_seen_ff <= 1'h0;
        stop_seen_ff <= 1'h1;
      end
      if (bit8_fall && st_ff == isar_pkg::ST_ADDR && addr_ok) begin
        rw_ff <= rw_bit;
        dna_ff <= 1'h0;
      end else if (bit8_fall && st_ff == isar_pkg::ST_DATA) begin
        dna_ff <= 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive buffer; a full buffer turns into a not-acknowledge
  isar_fifo #(
    .W(isar_pkg::RX_W),
    .DEPTH(isar_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_valid(push),
    .o_ready(fifo_ready),
    .i_data(push_word),
    .o_valid(o_rx_valid),
    .i_ready(i_rx_rd),
    .o_data(o_rx)
  );

  assign o_scl_o = 1'h0;
  assign o_scl_oe_n = ckp_ff && !ua_ff;
  assign o_sda_o = 1'h0;
  assign o_sda_oe_n = !(ack_drive_ff &&
                        cnt_ff == isar_pkg::ACK_SLOT);
  assign o_stat = '{event_flag: ev_ff, update_addr: ua_ff,
                    buf_full: !fifo_ready, rx_ovf: ovf_ff,
                    clk_release: ckp_ff, ack_time: ack_time_ff,
                    start_seen: start_seen_ff,
                    stop_seen: stop_seen_ff, rw: rw_ff,
                    data_n_addr: dna_ff};

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_nomatch_idle: assert property (
    bit8_fall && st_ff == isar_pkg::ST_ADDR && !addr_ok |=>
      st_ff == isar_pkg::ST_IDLE && !ack_drive_ff && !ua_pend_ff
  ) else $error("unmatched address not dropped");
  a_sda_ack_slot: assert property (
    !o_sda_oe_n |-> cnt_ff == isar_pkg::ACK_SLOT && active
  ) else $error("sda driven outside ack slot");
  a_ua_holds_scl: assert property (
    ua_ff |-> !o_scl_oe_n
  ) else $error("scl released while update flag set");
  a_addr_wr_clear: assert property (
    i_own_addr_wr && !(bit9_fall && ua_set9) |=> !ua_ff
  ) else $error("own address write kept update flag");
  a_event_sticky: assert property (
    ev_ff && !i_event_clr |=> ev_ff [*2] or (ev_ff ##1 i_event_clr)
  ) else $error("event flag lost without clear");
  a_ovf_nack: assert property (
    bit8_fall && overflow && !hold |=> !ack_drive_ff until bit9_fall
  ) else $error("acknowledge given during overflow");
  a_hold_stall: assert property (
    bit8_fall && accept && hold |=> !ckp_ff && ev_ff && ack_time_ff
  ) else $error("hold mode did not stall at eighth fall");
  a_ack_value: assert property (
    hold_pend_ff && ok_ff && !bit9_fall && !start_det && !stop_det |=>
      ack_drive_ff == !$past(i_ack_value)
  ) else $error("ack value not followed");
  a_stop_status: assert property (
    stop_det && !start_det |=> stop_seen_ff && !start_seen_ff &&
      st_ff == isar_pkg::ST_IDLE
  ) else $error("stop not recorded");
  a_read_needs_prior: assert property (
    bit8_fall && st_ff == isar_pkg::ST_ADDR && ten && rw_bit &&
      !prior_ff |=> st_ff == isar_pkg::ST_IDLE
  ) else $error("10-bit read accepted without prior match");
  a_nack_no_event: assert property (
    bit9_fall && !ack_drive_ff && !ua_set9 && !ev_ff |=> !ev_ff
  ) else $error("event set after not-acknowledge");

  c_addr_ack: cover property (
    bit8_fall && st_ff == isar_pkg::ST_ADDR && ack_ok);
  c_full_10b: cover property (
    bit9_fall && st_ff == isar_pkg::ST_ADDR_LO && ack_drive_ff);
  c_hold_data: cover property (
    bit8_fall && st_ff == isar_pkg::ST_DATA && hold);
  c_overflow: cover property (bit8_fall && overflow && accept);
endmodule : isar_top
`default_nettype wire

// file: sim/isar_master_model.sv
// Purpose: behavioural two-wire bus master that drives the slave receiver
// Assumes: wires resolved in tb; an output at 1 releases its line
// Notes: scl high 5 and low 7 system clocks per data bit, a 96 ns link clock
`default_nettype none
module isar_master_model (
  input wire logic i_clk, // system clock
  input wire logic i_scl, // resolved scl wire
  input wire logic i_sda, // resolved sda wire
  output logic o_scl, // scl drive, 0 pulls low
  output logic o_sda // sda drive, 0 pulls low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge i_clk);
  endtask : hw
  // a stretching slave just lengthens the wait for the high level
  task automatic rise();
    int k;
    k = 0;
    o_scl = 1'b1;
    while (i_scl !== 1'b1 && k < 4000) begin
      @(negedge i_clk);
      k++;
    end
    hw(5);
  endtask : rise
  task automatic start();
    o_sda = 1'b1;
    hw(5);
    rise();
    o_sda = 1'b0;
    hw(5);
    o_scl = 1'b0;
    hw(5);
  endtask : start
  task automatic stop();
    o_sda = 1'b0;
    hw(5);
    rise();
    o_sda = 1'b1;
    hw(5);
  endtask : stop
  // sda moves only while scl is low, two cycles after the fall
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda = b[i];
      hw(5);
      rise();
      o_scl = 1'b0;
      hw(2);
    end
    o_sda = 1'b1;
    hw(3);
    rise();
    ack = i_sda;
    o_scl = 1'b0;
    hw(6);
  endtask : wbyte
endmodule : isar_master_model
`default_nettype wire

// file: sim/tb.sv
// Purpose: self-checking bench of the two-wire slave receiver
// Assumes: pull-ups on both wires; pulses driven at falling clock edges
// Notes: one task per scenario; hangs end through the cycle ceiling
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 40000;
  localparam logic [4:0] REL = 5'h01;
  localparam logic [4:0] EVC = 5'h02;
  localparam logic [4:0] OVC = 5'h04;
  localparam logic [4:0] POP = 5'h08;
  localparam logic [4:0] OWR = 5'h10;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  isar_pkg::isar_cfg_t cfg = '0;
  logic [7:0] own = 8'h00;
  logic ackv = 1'b0;
  logic [4:0] pls = 5'h00;
  logic ack;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  logic m_scl, m_sda, scl_oe_n, sda_oe_n, scl_o, sda_o, rx_valid;
  isar_pkg::isar_rx_t rx;
  isar_pkg::isar_stat_t st;
  wire logic scl_w = m_scl & (scl_oe_n | scl_o);
  wire logic sda_w = m_sda & (sda_oe_n | sda_o);
  always #4 i_clk = ~i_clk;
  isar_top isar_top_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_scl(scl_w), .i_sda(sda_w), .o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n),
    .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_cfg(cfg), .i_own_addr(own),
    .i_own_addr_wr(pls[4]), .i_ack_value(ackv),
    .i_clk_release_set(pls[0]), .i_event_clr(pls[1]), .i_ovf_clr(pls[2]),
    .i_rx_rd(pls[3]), .o_rx(rx), .o_rx_valid(rx_valid), .o_stat(st));
  isar_master_model isar_master_model_inst (.i_clk(i_clk), .i_scl(scl_w),
    .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [4:0] m);
    @(negedge i_clk) pls = m;
    @(negedge i_clk) pls = 5'h00;
    repeat (2) @(negedge i_clk);
  endtask : pulse
  task automatic owr(input logic [7:0] v);
    own = v;
    pulse(OWR);
  endtask : owr
  task automatic drain();
    for (int k = 0; k < 20 && rx_valid === 1'b1; k++) pulse(POP);
    chk(rx_valid, 0);
  endtask : drain
  task automatic wait_hold();
    for (int k = 0; k < 300 && st.clk_release !== 1'b0; k++)
      @(negedge i_clk);
  endtask : wait_hold
  ////////////////////////////////////////////////////////////////////////
  task automatic t_7bit();
    cfg = '{isar_pkg::MODE_7B_SP, 1'b1, 1'b0, 1'b0, 1'b0};
    owr(8'h6a);
    isar_master_model_inst.start();
    chk({st.start_seen, st.event_flag}, 2'b11);
    pulse(EVC);
    isar_master_model_inst.wbyte(8'h6a, ack);
    chk({ack, st.rw, st.event_flag}, 3'b001);
    chk({st.clk_release, scl_w}, 2'b00);
    pulse(REL);
    isar_master_model_inst.wbyte(8'ha5, ack);
    chk(ack, 0);
    repeat (20) @(negedge i_clk);
    chk(st.event_flag, 1);
    pulse(REL);
    chk(rx, {1'b0, 8'h6a});
    pulse(POP);
    chk(rx, {1'b1, 8'ha5});
    drain();
    isar_master_model_inst.stop();
    chk(st.stop_seen, 1);
    isar_master_model_inst.start();
    isar_master_model_inst.wbyte(8'h6b, ack);
    chk({ack, st.rw}, 2'b01);
    pulse(REL);
    isar_master_model_inst.start();
    pulse(EVC);
    isar_master_model_inst.wbyte(8'h6e, ack);
    chk({ack, st.event_flag}, 2'b10);
    isar_master_model_inst.stop();
  endtask : t_7bit
  task automatic t_10bit();
    cfg = '{isar_pkg::MODE_10B, 1'b0, 1'b0, 1'b0, 1'b0};
    drain();
    pulse(EVC);
    owr(8'hf4);
    isar_master_model_inst.start();
    chk(st.event_flag, 0);
    isar_master_model_inst.wbyte(8'hf4, ack);
    chk({ack, st.update_addr, scl_w}, 3'b010);
    owr(8'h5c);
    chk(st.update_addr, 0);
    isar_master_model_inst.wbyte(8'h5c, ack);
    chk({ack, st.update_addr}, 2'b01);
    owr(8'hf4);
    isar_master_model_inst.start();
    isar_master_model_inst.wbyte(8'hf5, ack);
    chk(ack, 0);
    pulse(REL);
    isar_master_model_inst.start();
    isar_master_model_inst.wbyte(8'hf4, ack);
    owr(8'h5c);
    pulse(EVC);
    isar_master_model_inst.wbyte(8'h5d, ack);
    chk({ack, st.update_addr, st.event_flag, scl_w}, 4'he);
    owr(8'hf4);
    isar_master_model_inst.stop();
    isar_master_model_inst.start();
    isar_master_model_inst.wbyte(8'hf5, ack);
    chk(ack, 1);
    isar_master_model_inst.stop();
    drain();
  endtask : t_10bit
  task automatic t_ovf();
    cfg = '{isar_pkg::MODE_7B, 1'b0, 1'b0, 1'b0, 1'b0};
    owr(8'h6a);
    isar_master_model_inst.start();
    isar_master_model_inst.wbyte(8'h6a, ack);
    for (int i = 0; i < 15; i++)
      isar_master_model_inst.wbyte(8'(i), ack);
    chk({ack, st.buf_full}, 2'b01);
    isar_master_model_inst.wbyte(8'h55, ack);
    chk({ack, st.rx_ovf}, 2'b11);
    isar_master_model_inst.stop();
    isar_master_model_inst.start();
    isar_master_model_inst.wbyte(8'h6a, ack);
    chk(ack, 1);
    isar_master_model_inst.stop();
    drain();
    chk(st.buf_full, 0);
    pulse(OVC);
    chk(st.rx_ovf, 0);
  endtask : t_ovf
  task automatic t_hold();
    cfg = '{isar_pkg::MODE_7B, 1'b0, 1'b1, 1'b1, 1'b0};
    pulse(EVC);
    isar_master_model_inst.start();
    fork
      isar_master_model_inst.wbyte(8'h6a, ack);
      begin
        wait_hold();
        chk({st.event_flag, st.ack_time}, 2'b11);
        ackv = 1'b0;
        pulse(EVC | REL);
      end
    join
    chk({ack, st.event_flag}, 2'b01);
    pulse(EVC);
    fork
      isar_master_model_inst.wbyte(8'h33, ack);
      begin
        wait_hold();
        chk(st.event_flag, 1);
        ackv = 1'b1;
        pulse(EVC | REL);
      end
    join
    chk({ack, st.event_flag}, 2'b10);
    isar_master_model_inst.stop();
    drain();
  endtask : t_hold
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge i_clk);
    chk(st, 10'h020);
    chk({scl_oe_n, sda_oe_n, rx_valid}, 3'b110);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_clk);
    t_7bit();
    t_10bit();
    t_ovf();
    t_hold();
    summarize();
  end
endmodule : tb
`default_nettype wire
